// file: hw/pbi_params.svh
// constants for the bus pin interface: timing, commands, target window
// Function
// RULE1: transfer completes when both ready lows sampled
// RULE2: master holds frame low through transaction
// RULE3: address with frame, data in later clocks
// RULE4: command lines carry command, then byte enables
// RULE5: master drives even parity for address, writes
// RULE6: target drives even parity for read data
// RULE7: target pulls target-ready low when able
// RULE8: master pulls initiator-ready low when able
// RULE9: target unable to continue asserts stop
// RULE10: decoding agent drives device-select to claim
// RULE11: bus reset output low resets attached devices
// RULE12: strap high reverses address/data pin order
// RULE13: strap high reverses command/enable pin order
// RULE14: bus clock generated near 33 MHz, drives logic
// RULE15: arbiter serves up to three external masters
// RULE16: reset sequence starts from power good
// RULE17: strap sampled during reset, held until next
`ifndef PBI_PARAMS_SVH
`define PBI_PARAMS_SVH

`define PBI_CLK_MHZ 100
`define PBI_CLK_NS 10
`define PBI_BUS_CLK_MHZ 33
// divider ratio from system clock to bus clock
`define PBI_BUS_DIV (`PBI_CLK_MHZ / `PBI_BUS_CLK_MHZ)
// least time bus reset stays low after power good rises
`define PBI_RST_HOLD_NS 1000
`define PBI_RST_HOLD_CYC \
  ((`PBI_RST_HOLD_NS + `PBI_CLK_NS - 1) / `PBI_CLK_NS)
// bus clocks a master waits for device select
`define PBI_DEVSEL_TMO 5
`define PBI_CMD_MEM_RD 4'h6
`define PBI_CMD_MEM_WR 4'h7
`define PBI_TGT_BASE 32'h80000000
`define PBI_TGT_WORDS 4
`define PBI_MASTERS 3

`endif

// file: hw/pbi_pkg.sv
// types used by the two ends of the bus pin interface
package pbi_pkg;

  typedef enum logic [3:0] {
    TS_IDLE  = 4'b0001,
    TS_CLAIM = 4'b0010,
    TS_DATA  = 4'b0100,
    TS_TURN  = 4'b1000
  } pbi_tgt_state_type;

  typedef enum logic [4:0] {
    MS_IDLE = 5'b00001,
    MS_REQ  = 5'b00010,
    MS_ADDR = 5'b00100,
    MS_DATA = 5'b01000,
    MS_TURN = 5'b10000
  } pbi_mst_state_type;

  typedef enum logic [1:0] {
    ST_OK     = 2'h0,
    ST_RETRY  = 2'h1,
    ST_MABORT = 2'h2
  } pbi_status_type;

endpackage

// file: hw/pbi_if.sv
// bus wires between the device end and one external agent
interface pbi_if #(
  parameter int AGENT_IDX = 0
);
  logic bus_clock_output;
  logic bus_reset_output;
  logic [2:0] gnt_n;
  // device end drives
  logic [31:0] dv_ad_o;
  logic dv_ad_oe;
  logic dv_par_o;
  logic dv_par_oe;
  logic dv_devsel_o;
  logic dv_trdy_o;
  logic dv_stop_o;
  logic dv_ctl_oe;
  // agent end drives
  logic ag_req_n;
  logic [31:0] ag_ad_o;
  logic ag_ad_oe;
  logic [3:0] ag_cbe_o;
  logic ag_par_o;
  logic ag_par_oe;
  logic ag_frame_o;
  logic ag_frame_oe;
  logic ag_irdy_o;
  logic ag_mst_oe;
  // resolved wire levels, pulled high when nobody drives
  logic [31:0] ad;
  logic [3:0] cbe;
  logic par;
  logic frame_n;
  logic irdy_n;
  logic trdy_n;
  logic stop_n;
  logic devsel_n;
  logic [2:0] req_n;

  assign ad = dv_ad_oe ? dv_ad_o : (ag_ad_oe ? ag_ad_o : 32'hFFFFFFFF);
  assign cbe = ag_mst_oe ? ag_cbe_o : 4'hF;
  assign par = dv_par_oe ? dv_par_o : (ag_par_oe ? ag_par_o : 1'b1);
  assign frame_n = ag_frame_oe ? ag_frame_o : 1'b1;
  assign irdy_n = ag_mst_oe ? ag_irdy_o : 1'b1;
  assign trdy_n = dv_ctl_oe ? dv_trdy_o : 1'b1;
  assign stop_n = dv_ctl_oe ? dv_stop_o : 1'b1;
  assign devsel_n = dv_ctl_oe ? dv_devsel_o : 1'b1;
  assign req_n = ag_req_n ? 3'h7 : ~(3'h1 << AGENT_IDX);

  modport dev (
    output bus_clock_output, bus_reset_output, gnt_n,
    output dv_ad_o, dv_ad_oe, dv_par_o, dv_par_oe,
    output dv_devsel_o, dv_trdy_o, dv_stop_o, dv_ctl_oe,
    input ad, cbe, par, frame_n, irdy_n, devsel_n, req_n
  );

  modport agent (
    output ag_req_n, ag_ad_o, ag_ad_oe, ag_cbe_o, ag_par_o, ag_par_oe,
    output ag_frame_o, ag_frame_oe, ag_irdy_o, ag_mst_oe,
    input bus_clock_output, bus_reset_output, gnt_n,
    input ad, par, frame_n, irdy_n, trdy_n, stop_n, devsel_n
  );
endinterface

// file: hw/pbi_agent_end.sv
// external bus agent: requests the bus and runs single-word transfers
`include "pbi_params.svh"

module pbi_agent_end #(
  parameter int AGENT_IDX = 0,
  parameter int DEVSEL_TMO = `PBI_DEVSEL_TMO
) (
  input wire logic clk,
  input wire logic resetn,
  pbi_if.agent bus,
  input wire logic start,
  input wire logic wr,
  input wire logic [31:0] addr,
  input wire logic [31:0] wdata,
  input wire logic [3:0] be_n,
  output logic busy,
  output logic done,
  output logic [31:0] rdata,
  output pbi_pkg::pbi_status_type status,
  output logic par_err
);

  typedef struct packed {
    logic bclk_prev;
    pbi_pkg::pbi_mst_state_type state;
    logic wr;
    logic [31:0] addr;
    logic [31:0] wdata;
    logic [3:0] be_n;
    logic req_n;
    logic frame_o;
    logic frame_oe;
    logic irdy_o;
    logic mst_oe;
    logic [31:0] ad_o;
    logic ad_oe;
    logic [3:0] cbe_o;
    logic par_o;
    logic par_oe;
    logic [2:0] tmo;
    logic chk;
    logic chk_par;
    logic perr;
    logic busy;
    logic done;
    logic [31:0] rdata;
    pbi_pkg::pbi_status_type status;
  } pbi_agent_state_type;

  pbi_agent_state_type q;
  pbi_agent_state_type n;
  logic tick;

  // the device edge falls on the second low system cycle of the bus clock
  assign tick = !bus.bus_clock_output && !q.bclk_prev;

  always_comb begin
    n = q;
    n.bclk_prev = bus.bus_clock_output;
    n.done = 1'b0;
    n.perr = 1'b0;
    // latch a request only while idle, later starts are ignored
    if (start && !q.busy) begin
      n.busy = 1'b1;
      n.wr = wr;
      n.addr = addr;
      n.wdata = wdata;
      n.be_n = be_n;
    end
    if (!bus.bus_reset_output) begin
      // bus reset low holds the agent idle and off the wires [RULE11]
      n.state = pbi_pkg::MS_IDLE;
      n.req_n = 1'b1;
      n.frame_oe = 1'b0;
      n.mst_oe = 1'b0;
      n.ad_oe = 1'b0;
      n.par_oe = 1'b0;
      n.chk = 1'b0;
      n.busy = 1'b0;
    end else if (tick) begin
      // parity lags by one clock over what we drove [RULE5]
      n.par_oe = q.ad_oe;
      n.par_o = ^{q.ad_o, q.cbe_o}; // [RULE5]
      // read data parity, driven by the target, checked a clock later
      n.chk = 1'b0;
      n.perr = q.chk && (q.chk_par != bus.par); // [RULE6]
      case (q.state)
        pbi_pkg::MS_IDLE: begin
          n.mst_oe = 1'b0;
          if (q.busy) begin
            n.req_n = 1'b0;
            n.state = pbi_pkg::MS_REQ;
          end
        end
        pbi_pkg::MS_REQ: begin
          if (!bus.gnt_n[AGENT_IDX] && bus.frame_n && bus.irdy_n) begin
            n.req_n = 1'b1;
            n.frame_o = 1'b0; // [RULE2]
            n.frame_oe = 1'b1;
            n.irdy_o = 1'b1;
            n.mst_oe = 1'b1;
            n.ad_o = q.addr; // [RULE3]
            n.ad_oe = 1'b1;
            n.cbe_o = q.wr ? `PBI_CMD_MEM_WR : `PBI_CMD_MEM_RD; // [RULE4]
            n.tmo = 3'h0;
            n.state = pbi_pkg::MS_ADDR;
          end
        end
        pbi_pkg::MS_ADDR: begin
          // single data phase: frame rises as the last phase begins
          n.frame_o = 1'b1; // [RULE2]
          n.irdy_o = 1'b0; // [RULE8]
          n.cbe_o = q.be_n; // [RULE4]
          n.ad_o = q.wdata; // [RULE3]
          n.ad_oe = q.wr;
          n.state = pbi_pkg::MS_DATA;
        end
        pbi_pkg::MS_DATA: begin
          if (!q.irdy_o && !bus.trdy_n) begin
            n.status = pbi_pkg::ST_OK; // [RULE1]
            n.rdata = bus.ad;
            n.chk = !q.wr;
            n.chk_par = ^{bus.ad, q.cbe_o};
            n.state = pbi_pkg::MS_TURN;
          end else if (!bus.stop_n) begin
            n.status = pbi_pkg::ST_RETRY; // [RULE9]
            n.state = pbi_pkg::MS_TURN;
          end else if (bus.devsel_n) begin
            n.tmo = q.tmo + 3'h1;
            if (q.tmo == 3'(DEVSEL_TMO - 1)) begin
              n.status = pbi_pkg::ST_MABORT;
              n.state = pbi_pkg::MS_TURN;
            end
          end
          if (n.state == pbi_pkg::MS_TURN) begin
            // no data phase is left, so irdy must not stay low [RULE8]
            n.irdy_o = 1'b1;
            n.done = 1'b1;
            n.busy = 1'b0;
          end
        end
        pbi_pkg::MS_TURN: begin
          // irdy driven high one clock before release
          n.irdy_o = 1'b1;
          n.frame_oe = 1'b0;
          n.ad_oe = 1'b0;
          n.state = pbi_pkg::MS_IDLE;
        end
        default: n.state = pbi_pkg::MS_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      q <= '0;
      q.state <= pbi_pkg::MS_IDLE;
      q.req_n <= 1'b1;
      q.frame_o <= 1'b1;
      q.irdy_o <= 1'b1;
      q.cbe_o <= 4'hF;
      q.status <= pbi_pkg::ST_OK;
    end else begin
      q <= n;
    end
  end

  assign bus.ag_req_n = q.req_n;
  assign bus.ag_ad_o = q.ad_o;
  assign bus.ag_ad_oe = q.ad_oe;
  assign bus.ag_cbe_o = q.cbe_o;
  assign bus.ag_par_o = q.par_o;
  assign bus.ag_par_oe = q.par_oe;
  assign bus.ag_frame_o = q.frame_o;
  assign bus.ag_frame_oe = q.frame_oe;
  assign bus.ag_irdy_o = q.irdy_o;
  assign bus.ag_mst_oe = q.mst_oe;
  assign busy = q.busy;
  assign done = q.done;
  assign rdata = q.rdata;
  assign status = q.status;
  assign par_err = q.perr;

endmodule

// file: hw/pbi_dev_end.sv
// device end: bus clock and reset, arbiter, pin swap, memory target
`include "pbi_params.svh"

module pbi_dev_end #(
  parameter int BUS_DIV = `PBI_BUS_DIV,
  parameter int RST_HOLD_CYC = `PBI_RST_HOLD_CYC,
  parameter logic [31:0] TGT_BASE = `PBI_TGT_BASE,
  parameter int TGT_WORDS = `PBI_TGT_WORDS
) (
  input wire logic clk,
  input wire logic resetn,
  pbi_if.dev bus,
  input wire logic power_good_input,
  input wire logic pin_order_strap,
  output logic pin_swap,
  output logic wr_stb,
  output logic [31:0] wr_addr,
  output logic [31:0] wr_data,
  output logic par_err
);

  localparam int DW = (BUS_DIV > 2) ? $clog2(BUS_DIV) : 1;
  localparam int IW = $clog2(TGT_WORDS);
  localparam logic [31:0] AMASK = 32'(TGT_WORDS * 4 - 1);

  typedef struct packed {
    logic [DW-1:0] cnt;
    logic bclk;
    logic pg_s1;
    logic pg_s2;
    logic strap_s1;
    logic strap_s2;
    logic [15:0] rcnt;
    logic brst;
    logic swap;
    pbi_pkg::pbi_tgt_state_type state;
    logic [IW-1:0] idx;
    logic is_wr;
    logic frame_prev;
    logic [31:0] ad_o;
    logic ad_oe;
    logic par_o;
    logic par_oe;
    logic devsel_o;
    logic trdy_o;
    logic stop_o;
    logic ctl_oe;
    logic [2:0] gnt_n;
    logic [1:0] last;
    logic chk;
    logic chk_par;
    logic perr;
    logic [TGT_WORDS-1:0][31:0] mem;
    logic wr_stb;
    logic [31:0] wr_addr;
    logic [31:0] wr_data;
  } pbi_dev_state_type;

  pbi_dev_state_type q;
  pbi_dev_state_type n;
  logic tick;
  logic [31:0] ad_in;
  logic [3:0] cbe_in;
  logic [31:0] rd_word;
  logic [31:0] rd_pin;

  // one rising bus clock edge per divider wrap [RULE14]
  assign tick = (q.cnt == DW'(BUS_DIV - 1));
  assign rd_word = q.mem[q.idx];

  // pin order mapping in both directions, fixed by the latched strap
  for (genvar i = 0; i < 32; i++) begin : g_swap
    assign ad_in[i] = q.swap ? bus.ad[31 - i] : bus.ad[i]; // [RULE12]
    assign rd_pin[i] = q.swap ? rd_word[31 - i] : rd_word[i]; // [RULE12]
    if (i < 4) begin : g_cbe
      assign cbe_in[i] = q.swap ? bus.cbe[3 - i] : bus.cbe[i]; // [RULE13]
    end
  end

  always_comb begin
    logic keep;
    logic found;
    logic [1:0] j;
    logic [31:0] merged;
    keep = 1'b0;
    found = 1'b0;
    j = 2'h0;
    merged = 32'h00000000;
    n = q;
    n.wr_stb = 1'b0;
    n.perr = 1'b0;
    // bus clock: high for the first system cycle of each period [RULE14]
    n.cnt = tick ? '0 : q.cnt + DW'(1);
    n.bclk = tick;
    // power good and strap come from pins, two flops before use
    n.pg_s1 = power_good_input;
    n.pg_s2 = q.pg_s1;
    n.strap_s1 = pin_order_strap;
    n.strap_s2 = q.strap_s1;
    // bus reset released only after power good has stood for the hold
    if (!q.pg_s2) begin
      n.rcnt = 16'h0000; // [RULE16]
      n.brst = 1'b0; // [RULE11]
    end else if (q.rcnt != 16'(RST_HOLD_CYC)) begin
      n.rcnt = q.rcnt + 16'h0001; // [RULE16]
    end else begin
      n.brst = 1'b1; // [RULE11]
    end
    // strap tracked while bus reset is low, frozen once it rises
    if (!q.brst) begin
      n.swap = q.strap_s2; // [RULE17]
    end
    if (!q.brst) begin
      // our own bus logic sits in reset with the attached devices
      n.state = pbi_pkg::TS_IDLE; // [RULE11]
      n.ctl_oe = 1'b0;
      n.ad_oe = 1'b0;
      n.par_oe = 1'b0;
      n.gnt_n = 3'h7;
      n.chk = 1'b0;
      n.frame_prev = 1'b1;
    end else if (tick) begin
      // read parity follows our data by one clock [RULE6]
      n.par_oe = q.ad_oe;
      n.par_o = ^{q.ad_o, bus.cbe}; // [RULE6]
      // write data parity is checked a clock after the transfer
      n.chk = 1'b0;
      n.perr = q.chk && (q.chk_par != bus.par); // [RULE5]
      n.frame_prev = bus.frame_n;
      case (q.state)
        pbi_pkg::TS_IDLE: begin
          n.ctl_oe = 1'b0;
          // address phase is the first clock with frame low [RULE3]
          if (!bus.frame_n && q.frame_prev &&
              ((ad_in & ~AMASK) == TGT_BASE) &&
              (cbe_in == `PBI_CMD_MEM_RD ||
               cbe_in == `PBI_CMD_MEM_WR)) begin // [RULE4]
            n.idx = ad_in[IW+1:2];
            n.is_wr = (cbe_in == `PBI_CMD_MEM_WR);
            n.devsel_o = 1'b0; // [RULE10]
            n.trdy_o = 1'b1;
            n.stop_o = 1'b1;
            n.ctl_oe = 1'b1;
            n.state = pbi_pkg::TS_CLAIM;
          end
        end
        pbi_pkg::TS_CLAIM: begin
          // read data waits one clock here for the turnaround
          n.trdy_o = 1'b0; // [RULE7]
          // one word per transaction: a burst is disconnected [RULE9]
          n.stop_o = bus.frame_n;
          n.ad_o = rd_pin;
          n.ad_oe = !q.is_wr;
          n.state = pbi_pkg::TS_DATA;
        end
        pbi_pkg::TS_DATA: begin
          if (!bus.irdy_n && !q.trdy_o) begin // [RULE1]
            if (q.is_wr) begin
              merged = q.mem[q.idx];
              for (int b = 0; b < 4; b++) begin
                if (!cbe_in[b]) begin
                  merged[8*b +: 8] = ad_in[8*b +: 8]; // [RULE4]
                end
              end
              n.mem[q.idx] = merged;
              n.wr_stb = 1'b1;
              n.wr_addr = TGT_BASE | 32'({q.idx, 2'b00});
              n.wr_data = merged;
              n.chk = 1'b1;
              n.chk_par = ^{bus.ad, bus.cbe};
            end
            // drive controls high one clock before letting go
            n.devsel_o = 1'b1;
            n.trdy_o = 1'b1;
            n.stop_o = 1'b1;
            n.ad_oe = 1'b0;
            n.state = pbi_pkg::TS_TURN;
          end
        end
        pbi_pkg::TS_TURN: begin
          n.ctl_oe = 1'b0;
          n.state = pbi_pkg::TS_IDLE;
        end
        default: n.state = pbi_pkg::TS_IDLE;
      endcase
      // round robin among requesters, only moved while the bus is idle
      keep = (q.gnt_n != 3'h7) && |(~bus.req_n & ~q.gnt_n);
      if (!keep && bus.frame_n && bus.irdy_n) begin
        n.gnt_n = 3'h7;
        for (int k = 1; k <= `PBI_MASTERS; k++) begin
          j = 2'((int'(q.last) + k) % `PBI_MASTERS);
          if (!found && !bus.req_n[j]) begin
            n.gnt_n[j] = 1'b0; // [RULE15]
            n.last = j;
            found = 1'b1;
          end
        end
      end
    end
  end

  // one register stage for the whole end; every output comes from it
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      q <= '0;
      q.state <= pbi_pkg::TS_IDLE;
      q.devsel_o <= 1'b1;
      q.trdy_o <= 1'b1;
      q.stop_o <= 1'b1;
      q.gnt_n <= 3'h7;
      q.frame_prev <= 1'b1;
    end else begin
      q <= n;
    end
  end

  assign bus.bus_clock_output = q.bclk;
  assign bus.bus_reset_output = q.brst;
  assign bus.gnt_n = q.gnt_n;
  assign bus.dv_ad_o = q.ad_o;
  assign bus.dv_ad_oe = q.ad_oe;
  assign bus.dv_par_o = q.par_o;
  assign bus.dv_par_oe = q.par_oe;
  assign bus.dv_devsel_o = q.devsel_o;
  assign bus.dv_trdy_o = q.trdy_o;
  assign bus.dv_stop_o = q.stop_o;
  assign bus.dv_ctl_oe = q.ctl_oe;
  assign pin_swap = q.swap;
  assign wr_stb = q.wr_stb;
  assign wr_addr = q.wr_addr;
  assign wr_data = q.wr_data;
  assign par_err = q.perr;

endmodule

// file: testbench/pbi_assertions.sv
// bus-wire checks of the pin interface; phase checks sampled once per bus cycle, clock, grant and reset checks every system cycle
module pbi_assertions #(
  parameter logic [31:0] TGT_BASE = 32'h80000000
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic bus_clock_output,
  input wire logic bus_reset_output,
  input wire logic [2:0] gnt_n,
  input wire logic [31:0] ad,
  input wire logic [3:0] cbe,
  input wire logic par,
  input wire logic frame_n,
  input wire logic irdy_n,
  input wire logic trdy_n,
  input wire logic stop_n,
  input wire logic devsel_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic smp;
  logic in_win;
  logic cmd_wr_q;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  // wires hold for a whole bus cycle, so one look just after the rise
  assign smp = bus_clock_output & bus_reset_output;
  assign in_win = (ad[31:4] == TGT_BASE[31:4]);

  // command of the running transfer decides who owns the parity line
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cmd_wr_q <= 1'b0;
    end else if (smp && !frame_n) begin
      cmd_wr_q <= cbe[0];
    end
  end

  sequence low_two;
    !bus_clock_output ##1 !bus_clock_output ##1 bus_clock_output;
  endsequence

  sequence claim_ready;
    !devsel_n ##3 (!trdy_n && !devsel_n && stop_n);
  endsequence

  sequence parity_back;
    par == ^{$past(ad, 3), $past(cbe, 3)};
  endsequence

  clk_period_a: assert property (
    $rose(bus_clock_output) |=> low_two)
    else $error("bus clock period is not three cycles");
  grant_onehot_a: assert property ($onehot0(~gnt_n))
    else $error("more than one grant at once");
  reset_quiet_a: assert property (
    !bus_reset_output ##1 !bus_reset_output |->
    frame_n && irdy_n && devsel_n && (gnt_n == 3'h7))
    else $error("bus active while bus reset is low");
  addr_cmd_a: assert property (
    smp && !frame_n |-> (cbe == 4'h6 || cbe == 4'h7))
    else $error("address phase without a memory command");
  frame_hold_a: assert property (
    smp && !frame_n |-> ##3 (frame_n && !irdy_n))
    else $error("frame or initiator ready wrong after address");
  addr_par_a: assert property (
    smp && !frame_n |-> ##3 parity_back)
    else $error("address parity not even");
  wdata_par_a: assert property (
    smp && !irdy_n && !trdy_n && cmd_wr_q |-> parity_back)
    else $error("write data parity not even");
  rdata_par_a: assert property (
    smp && !irdy_n && !trdy_n && !cmd_wr_q |-> ##3 parity_back)
    else $error("read data parity not even");
  target_claim_a: assert property (
    smp && !frame_n && in_win |-> ##3 claim_ready)
    else $error("target window address not claimed in time");
  xfer_end_a: assert property (
    smp && !irdy_n && !trdy_n |-> ##3 (irdy_n && trdy_n && devsel_n))
    else $error("ready lines not raised after the transfer");
endmodule

// file: testbench/tb_pci_bus_pin_interface.sv
// bench: agent and device ends joined, plus a device end driven by hand
module tb_pci_bus_pin_interface;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int RST_HOLD = 4;
  localparam logic [31:0] BASE = 32'h80000000;
  localparam int LIMIT = 8000;
  logic clk, resetn, power_good_input, pin_order_strap, start, wr;
  logic [31:0] addr, wdata, rdata, wr_addr, wr_data, last_wa, last_wd;
  logic [3:0] be_n;
  logic busy, done, pin_swap, wr_stb, dev_perr, ag_perr, perr_b;
  logic seen_perr_a, seen_perr_b;
  logic [31:0] mem [4];
  pbi_pkg::pbi_status_type status;
  int fail_count, checked, cycles, n;

  pbi_if #(.AGENT_IDX(0)) bus_if ();
  pbi_if #(.AGENT_IDX(0)) bus_b ();

  pbi_dev_end #(.RST_HOLD_CYC(RST_HOLD)) i_pbi_dev_end (
    .clk(clk), .resetn(resetn), .bus(bus_if.dev),
    .power_good_input(power_good_input), .pin_order_strap(pin_order_strap),
    .pin_swap(pin_swap), .wr_stb(wr_stb), .wr_addr(wr_addr),
    .wr_data(wr_data), .par_err(dev_perr));
  pbi_agent_end i_pbi_agent_end (
    .clk(clk), .resetn(resetn), .bus(bus_if.agent), .start(start),
    .wr(wr), .addr(addr), .wdata(wdata), .be_n(be_n), .busy(busy),
    .done(done), .rdata(rdata), .status(status), .par_err(ag_perr));
  // second device end faces the bench, which breaks the rules on purpose
  pbi_dev_end #(.RST_HOLD_CYC(RST_HOLD)) i_pbi_dev_end_b (
    .clk(clk), .resetn(resetn), .bus(bus_b.dev),
    .power_good_input(power_good_input), .pin_order_strap(pin_order_strap),
    .pin_swap(), .wr_stb(), .wr_addr(), .wr_data(), .par_err(perr_b));
  pbi_assertions #(.TGT_BASE(BASE)) i_pbi_assertions (
    .clk(clk), .resetn(resetn),
    .bus_clock_output(bus_if.bus_clock_output),
    .bus_reset_output(bus_if.bus_reset_output), .gnt_n(bus_if.gnt_n),
    .ad(bus_if.ad), .cbe(bus_if.cbe), .par(bus_if.par),
    .frame_n(bus_if.frame_n), .irdy_n(bus_if.irdy_n),
    .trdy_n(bus_if.trdy_n), .stop_n(bus_if.stop_n),
    .devsel_n(bus_if.devsel_n));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // pulses are caught here so tasks need not race them; also the hang limit
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (wr_stb === 1'b1) begin
      last_wa <= wr_addr;
      last_wd <= wr_data;
    end
    if (ag_perr === 1'b1 || dev_perr === 1'b1) seen_perr_a <= 1'b1;
    if (perr_b === 1'b1) seen_perr_b <= 1'b1;
    if (cycles == LIMIT) begin
      fail_count++;
      report_and_stop();
    end
  end

  function automatic logic [31:0] merge(input logic [31:0] o,
      input logic [31:0] d, input logic [3:0] b);
    for (int k = 0; k < 4; k++) begin
      if (!b[k]) o[8*k +: 8] = d[8*k +: 8];
    end
    return o;
  endfunction

  function automatic logic [31:0] bitrev(input logic [31:0] d);
    logic [31:0] r;
    for (int k = 0; k < 32; k++) r[k] = d[31-k];
    return r;
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_st(input pbi_pkg::pbi_status_type got,
      input pbi_pkg::pbi_status_type exp);
    chk({30'h0, got}, {30'h0, exp});
  endtask

  // one user-side transfer of the agent, waiting for done under a bound
  task automatic xfer(input logic w, input logic [31:0] a,
      input logic [31:0] d, input logic [3:0] b);
    int k;
    @(posedge clk);
    start <= 1'b1;
    wr <= w;
    addr <= a;
    wdata <= d;
    be_n <= b;
    @(posedge clk);
    start <= 1'b0;
    @(negedge clk);
    chk({31'h0, busy}, 32'h1);
    k = 0;
    // done stands one cycle: look in mid-cycle, where it is settled
    do begin
      @(negedge clk);
      k++;
    end while (done !== 1'b1 && k < 400);
    chk({31'h0, done}, 32'h1);
    // write pulses are copied at the next rise; let that edge pass
    repeat (2) @(posedge clk);
  endtask

  task automatic wr_word(input logic [31:0] a, input logic [31:0] d,
      input logic [3:0] b);
    xfer(1'b1, a, d, b);
    mem[a[3:2]] = merge(mem[a[3:2]], d, b);
    chk_st(status, pbi_pkg::ST_OK);
    chk(last_wa, a);
    chk(last_wd, mem[a[3:2]]);
  endtask

  task automatic rd_word(input logic [31:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0, 4'h0);
    chk_st(status, pbi_pkg::ST_OK);
    chk(rdata, e);
  endtask

  // bus clock rises at every third edge after a high sample
  task automatic tick_b();
    do @(posedge clk); while (bus_b.bus_clock_output !== 1'b1);
    repeat (2) @(posedge clk);
  endtask

  task automatic idle_b();
    bus_b.ag_req_n <= 1'b1;
    bus_b.ag_ad_oe <= 1'b0;
    bus_b.ag_par_oe <= 1'b0;
    bus_b.ag_frame_o <= 1'b1;
    bus_b.ag_frame_oe <= 1'b0;
    bus_b.ag_irdy_o <= 1'b1;
    bus_b.ag_mst_oe <= 1'b0;
  endtask

  task automatic wait_link();
    n = 0;
    while (bus_if.bus_reset_output !== 1'b1 && n < 500) begin
      @(posedge clk);
      n++;
    end
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    resetn = 1'b0;
    power_good_input = 1'b0;
    pin_order_strap = 1'b0;
    start = 1'b0;
    wr = 1'b0;
    addr = 32'h0;
    wdata = 32'h0;
    be_n = 4'hF;
    seen_perr_a = 1'b0;
    seen_perr_b = 1'b0;
    mem = '{default: 32'h0};
    bus_b.ag_ad_o = 32'h0;
    bus_b.ag_cbe_o = 4'hF;
    bus_b.ag_par_o = 1'b0;
    idle_b();
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    repeat (40) @(posedge clk);
    chk({31'h0, bus_if.bus_reset_output}, 32'h0);
    chk({31'h0, pin_swap}, 32'h0);
    power_good_input <= 1'b1;
    wait_link();
    chk(32'(n > RST_HOLD && n <= RST_HOLD + 8), 32'h1);
    for (int i = 0; i < 4; i++) begin
      wr_word(BASE + 32'(4 * i), 32'hA5C30F10 + 32'(i), 4'h0);
    end
    wr_word(BASE + 32'h4, 32'h11223344, 4'h5);
    wr_word(BASE + 32'hC, 32'hFFFFFFFF, 4'hF);
    for (int i = 0; i < 4; i++) rd_word(BASE + 32'(4 * i), mem[i]);
    xfer(1'b0, BASE + 32'h10, 32'h0, 4'h0);
    chk_st(status, pbi_pkg::ST_MABORT);
    // burst write on the hand-driven bus with bad data parity
    bus_b.ag_req_n <= 1'b0;
    do tick_b(); while (bus_b.gnt_n[0] !== 1'b0);
    bus_b.ag_frame_oe <= 1'b1;
    bus_b.ag_frame_o <= 1'b0;
    bus_b.ag_ad_oe <= 1'b1;
    bus_b.ag_ad_o <= BASE;
    bus_b.ag_mst_oe <= 1'b1;
    bus_b.ag_cbe_o <= 4'h7;
    bus_b.ag_req_n <= 1'b1;
    tick_b();
    bus_b.ag_irdy_o <= 1'b0;
    bus_b.ag_cbe_o <= 4'h0;
    bus_b.ag_ad_o <= 32'h5A5A0001;
    bus_b.ag_par_oe <= 1'b1;
    bus_b.ag_par_o <= ^{BASE, 4'h7};
    tick_b();
    bus_b.ag_par_o <= ~^{32'h5A5A0001, 4'h0};
    n = 0;
    do begin
      tick_b();
      n++;
    end while (bus_b.trdy_n !== 1'b0 && n < 8);
    chk({31'h0, bus_b.stop_n}, 32'h0);
    chk({31'h0, bus_b.devsel_n}, 32'h0);
    bus_b.ag_frame_o <= 1'b1;
    bus_b.ag_irdy_o <= 1'b1;
    tick_b();
    idle_b();
    repeat (4) tick_b();
    chk({31'h0, seen_perr_b}, 32'h1);
    // strap is taken only while bus reset is low, then frozen
    power_good_input <= 1'b0;
    repeat (10) @(posedge clk);
    chk({31'h0, bus_if.bus_reset_output}, 32'h0);
    pin_order_strap <= 1'b1;
    repeat (10) @(posedge clk);
    power_good_input <= 1'b1;
    wait_link();
    chk({31'h0, pin_swap}, 32'h1);
    pin_order_strap <= 1'b0;
    repeat (10) @(posedge clk);
    chk({31'h0, pin_swap}, 32'h1);
    rd_word(bitrev(BASE), bitrev(mem[0]));
    // read parity is checked one bus clock after done
    repeat (6) @(posedge clk);
    chk({31'h0, seen_perr_a}, 32'h0);
    report_and_stop();
  end
endmodule
